// ---- rtl/fisr_pkg.sv ----
// ==============================
// shared constants and types
package fisr_pkg;
	// ==============================
	// opcodes
	localparam logic [7:0] OPC_QUAD_ID = 8'h94;
	localparam logic [7:0] OPC_UNIQUE_ID = 8'h4B;
	localparam logic [7:0] OPC_JEDEC_ID = 8'h9F;
	localparam logic [7:0] OPC_PARAM_TABLE = 8'h5A;
	localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
	localparam logic [7:0] OPC_SEC_PROG = 8'h42;
	localparam logic [7:0] OPC_SEC_READ = 8'h48;
	localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
	// ==============================
	// rising-edge counts within a frame
	localparam logic [5:0] CNT_OPCODE = 6'h08;
	localparam logic [5:0] CNT_QID_ADDR = 6'h0C;
	localparam logic [5:0] CNT_QID_DATA = 6'h12;
	localparam logic [5:0] CNT_ADDR_DONE = 6'h20;
	localparam logic [5:0] CNT_DUMMY_DONE = 6'h28;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	// ==============================
	// security register address fields
	localparam logic [7:0] SEL_HIGH_ZERO = 8'h00;
	localparam logic [3:0] SEL_MID_ZERO = 4'h0;
	localparam logic [3:0] SEL_REG_FIRST = 4'h1;
	localparam logic [3:0] SEL_REG_LAST = 4'h3;
	localparam int REG_COUNT = 3;
	localparam int REG_BYTES = 256;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// ==============================
	// identity values, all arbitrary
	localparam logic [7:0] MANUF_ID = 8'h5C;
	localparam logic [7:0] QUAD_DEVICE_ID = 8'h21;
	localparam logic [7:0] MEMORY_TYPE = 8'h33;
	localparam logic [7:0] CAPACITY = 8'h44;
	localparam logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF;
	// ==============================
	// self-timed operation lengths
	localparam int CLOCK_MHZ = 250;
	localparam int ERASE_TIME_US = 200;
	localparam int PROG_TIME_US = 40;
	localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CLOCK_MHZ;
	localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLOCK_MHZ;
	localparam int TIMER_W = 24;
	// ==============================
	// types
	typedef enum logic [3:0] {
		CMD_IDLE, CMD_QID, CMD_UID, CMD_JID, CMD_PTAB,
		CMD_ERASE, CMD_PROG, CMD_READ, CMD_WREN, CMD_WRDI, CMD_IGNORE
	} fisr_cmd_t;
	typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROG} fisr_op_t;
	typedef struct packed {
		logic csN;
		logic sclk;
		logic [3:0] io;
	} fisr_pins_t;
	typedef struct packed {
		logic busy;
		logic writeEnableLatch;
	} fisr_status_t;
	localparam fisr_pins_t PINS_IDLE = '{csN: 1'b1, sclk: 1'b0, io: 4'h0};
	// parameter table contents; unlisted bytes read erased
	function automatic logic [7:0] paramTableByte(input logic [7:0] a);
		case (a)
			8'h00: paramTableByte = 8'h50;
			8'h01: paramTableByte = 8'h54;
			8'h02: paramTableByte = 8'h41;
			8'h03: paramTableByte = 8'h42;
			default: paramTableByte = ERASED_BYTE;
		endcase
	endfunction
endpackage

// ---- rtl/fisr_pin_sync.sv ----
`timescale 1ns/1ps
// ==============================
// three-stage synchroniser, a bit moves once stages two and three agree
module fisr_pin_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] stable
);
	logic [W-1:0] s1_r; // read only by s2_r
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	// shift chain
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// agreement filter, per bit
	always_ff @(posedge clock) begin
		if (rst) begin
			stable <= INIT;
		end else begin
			stable <= (s2_r & s3_r) | (stable & (s2_r | s3_r));
		end
	end
endmodule

// ---- rtl/fisr_op_timer.sv ----
`timescale 1ns/1ps
// ==============================
// down counter for self-timed cycles
module fisr_op_timer (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [fisr_pkg::TIMER_W-1:0] load,
	output logic running,
	output logic done
);
	logic [fisr_pkg::TIMER_W-1:0] count_r; // cycles left
	// count down, pulse done on the last cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			count_r <= '0;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_r <= load;
				running <= 1'b1;
			end else if (running) begin
				if (count_r <= 1) begin
					running <= 1'b0;
					done <= 1'b1;
				end else begin
					count_r <= count_r - 1'b1;
				end
			end
		end
	end
endmodule

// ---- rtl/fisr_core.sv ----
`timescale 1ns/1ps
// Functional notes
// - quad ID: opcode, four dummies, quad address
// - quad ID: maker then device, nibbles
// - quad ID repeats pair until deselect
// - unique ID after four dummy bytes
// - three-byte ID: maker, type, capacity
// - table read starts at clock forty
// - three registers picked by address fields
// - erase needs write enable latch set
// - erase dropped unless deselect after address
// - self-timed erase holds busy high
// - erase completion clears write enable latch
// - locked register ignores erase
// - program takes address plus data bytes
// - locked register ignores program
// - register read after address and dummies
// - read address wraps inside register
// - register read ignored while busy
// - power-down ignores all these commands
module fisr_core #(
	parameter int unsigned ERASE_CYCLES = fisr_pkg::ERASE_CYCLES_DEF,
	parameter int unsigned PROG_CYCLES = fisr_pkg::PROG_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire fisr_pkg::fisr_pins_t spiPins,
	input wire logic [2:0] securityLockBits,
	input wire logic powerDown,
	output logic [3:0] ioOut,
	output logic [3:0] ioOeN,
	output fisr_pkg::fisr_status_t status
);
	// ==============================
	// declarations
	fisr_pkg::fisr_pins_t pinsS; // filtered pins
	logic prevSclk_r; // for edge detect
	logic prevCsN_r;
	logic sclkRise, sclkFall, csRise; // qualified edges
	logic [5:0] rxCnt_r; // rising edges this frame
	logic [31:0] shiftIn_r; // input shifter
	logic [31:0] shiftNxt;
	logic quadIn; // address nibbles in quad ID
	fisr_pkg::fisr_cmd_t cmd_r; // decoded command
	logic [1:0] regNum_r; // register 0..2
	logic selOk_r; // address hit a register
	logic [7:0] byteIdx_r; // byte pointer
	logic [7:0] byteIdxNxt;
	logic [2:0] progBit_r; // bits of current data byte
	logic progAny_r; // a byte was programmed
	logic progByteDone, progAllowed, memWrite; // program strobes
	logic [7:0] outByte_r; // output shifter
	logic [2:0] outPos_r; // bits sent of this byte
	logic dataPhase;
	logic [7:0] fetchByte;
	logic [5:0] startCnt;
	fisr_pkg::fisr_op_t op_r; // running cycle
	logic [1:0] opReg_r; // register under erase
	logic [8:0] erasePtr_r; // erase sweep
	logic timerStart_r;
	logic [fisr_pkg::TIMER_W-1:0] timerLoad_r;
	logic timerDone;
	logic [7:0] secMem [0:fisr_pkg::REG_COUNT-1][0:fisr_pkg::REG_BYTES-1];
	// ==============================
	// pins and edges
	fisr_pin_sync #(
		.W(6),
		.INIT(fisr_pkg::PINS_IDLE)
	) pinSync (
		.clock(clock),
		.rst(rst),
		.raw(spiPins),
		.stable(pinsS)
	);
	// previous filtered levels
	always_ff @(posedge clock) begin
		if (rst) begin
			prevSclk_r <= 1'b0;
			prevCsN_r <= 1'b1;
		end else begin
			prevSclk_r <= pinsS.sclk;
			prevCsN_r <= pinsS.csN;
		end
	end
	// clock edges count only while selected
	assign sclkRise = pinsS.sclk & ~prevSclk_r & ~pinsS.csN;
	assign sclkFall = ~pinsS.sclk & prevSclk_r & ~pinsS.csN;
	assign csRise = pinsS.csN & ~prevCsN_r;
	// ==============================
	// command decode
	function automatic fisr_pkg::fisr_cmd_t decodeCmd(
		input logic [7:0] opc,
		input logic pd,
		input logic bsy
	);
		decodeCmd = fisr_pkg::CMD_IGNORE;
		if (!pd) begin
			case (opc)
				fisr_pkg::OPC_QUAD_ID: decodeCmd = fisr_pkg::CMD_QID;
				fisr_pkg::OPC_UNIQUE_ID: decodeCmd = fisr_pkg::CMD_UID;
				fisr_pkg::OPC_JEDEC_ID: decodeCmd = fisr_pkg::CMD_JID;
				fisr_pkg::OPC_PARAM_TABLE: decodeCmd = fisr_pkg::CMD_PTAB;
				// busy blocks everything touching the registers
				fisr_pkg::OPC_SEC_READ: if (!bsy) decodeCmd = fisr_pkg::CMD_READ;
				fisr_pkg::OPC_SEC_ERASE: if (!bsy) decodeCmd = fisr_pkg::CMD_ERASE;
				fisr_pkg::OPC_SEC_PROG: if (!bsy) decodeCmd = fisr_pkg::CMD_PROG;
				fisr_pkg::OPC_WRITE_ENABLE: if (!bsy) decodeCmd = fisr_pkg::CMD_WREN;
				fisr_pkg::OPC_WRITE_DISABLE: if (!bsy) decodeCmd = fisr_pkg::CMD_WRDI;
				default: decodeCmd = fisr_pkg::CMD_IGNORE;
			endcase
		end
	endfunction
	// register select from the address fields
	function automatic logic addrSel(input logic [23:0] a);
		addrSel = (a[23:16] == fisr_pkg::SEL_HIGH_ZERO)
			&& (a[11:8] == fisr_pkg::SEL_MID_ZERO)
			&& (a[15:12] >= fisr_pkg::SEL_REG_FIRST)
			&& (a[15:12] <= fisr_pkg::SEL_REG_LAST);
	endfunction
	// ==============================
	// receive side
	// quad address nibbles follow the four dummies
	assign quadIn = (cmd_r == fisr_pkg::CMD_QID) && (rxCnt_r >= fisr_pkg::CNT_QID_ADDR);
	assign shiftNxt = quadIn ? {shiftIn_r[27:0], pinsS.io} : {shiftIn_r[30:0], pinsS.io[0]};
	// bit counter, shifter and opcode latch
	always_ff @(posedge clock) begin
		if (rst || pinsS.csN) begin
			rxCnt_r <= '0;
			shiftIn_r <= '0;
			cmd_r <= fisr_pkg::CMD_IDLE;
		end else if (sclkRise) begin
			shiftIn_r <= shiftNxt;
			// saturate, later edges only matter as "more"
			if (rxCnt_r != fisr_pkg::CNT_MAX) rxCnt_r <= rxCnt_r + 1'b1;
			if (rxCnt_r == fisr_pkg::CNT_OPCODE - 1'b1) begin
				cmd_r <= decodeCmd(shiftNxt[7:0], powerDown, status.busy);
			end
		end
	end
	// register select at the last address bit
	always_ff @(posedge clock) begin
		if (rst) begin
			regNum_r <= '0;
			selOk_r <= 1'b0;
		end else if (sclkRise && rxCnt_r == fisr_pkg::CNT_ADDR_DONE - 1'b1
			&& cmd_r != fisr_pkg::CMD_QID) begin
			regNum_r <= shiftNxt[13:12] - 2'h1;
			selOk_r <= addrSel(shiftNxt[23:0]);
		end
	end
	// ==============================
	// program data path
	assign progAllowed = status.writeEnableLatch && selOk_r
		&& !securityLockBits[regNum_r];
	assign progByteDone = sclkRise && (cmd_r == fisr_pkg::CMD_PROG)
		&& (rxCnt_r >= fisr_pkg::CNT_ADDR_DONE) && (progBit_r == 3'h7);
	assign memWrite = progByteDone && progAllowed;
	// data bit counter and "something written" flag
	always_ff @(posedge clock) begin
		if (rst || pinsS.csN) begin
			progBit_r <= '0;
			progAny_r <= 1'b0;
		end else if (sclkRise && cmd_r == fisr_pkg::CMD_PROG
			&& rxCnt_r >= fisr_pkg::CNT_ADDR_DONE) begin
			progBit_r <= progBit_r + 1'b1;
			if (memWrite) progAny_r <= 1'b1;
		end
	end
	// ==============================
	// byte pointer, shared by reads and program
	// three-byte ID wraps after capacity, the rest after 8'hFF
	assign byteIdxNxt = (cmd_r == fisr_pkg::CMD_JID && byteIdx_r == 8'h02)
		? 8'h00 : byteIdx_r + 8'h01;
	always_ff @(posedge clock) begin
		if (rst || pinsS.csN) begin
			byteIdx_r <= '0;
		end else if (sclkRise && rxCnt_r == fisr_pkg::CNT_ADDR_DONE - 1'b1
			&& (cmd_r == fisr_pkg::CMD_PTAB || cmd_r == fisr_pkg::CMD_READ
			|| cmd_r == fisr_pkg::CMD_PROG)) begin
			byteIdx_r <= shiftNxt[7:0];
		end else if (progByteDone) begin
			byteIdx_r <= byteIdxNxt;
		end else if (sclkFall && dataPhase && outPos_r == 3'h0) begin
			// advance once the byte has been fetched
			byteIdx_r <= byteIdxNxt;
		end
	end
	// ==============================
	// output side
	// first data edge is the fall after the last input rise
	always_comb begin
		case (cmd_r)
			fisr_pkg::CMD_QID: startCnt = fisr_pkg::CNT_QID_DATA;
			fisr_pkg::CMD_UID: startCnt = fisr_pkg::CNT_DUMMY_DONE;
			fisr_pkg::CMD_JID: startCnt = fisr_pkg::CNT_OPCODE;
			fisr_pkg::CMD_PTAB: startCnt = fisr_pkg::CNT_DUMMY_DONE;
			fisr_pkg::CMD_READ: startCnt = fisr_pkg::CNT_DUMMY_DONE;
			default: startCnt = fisr_pkg::CNT_MAX;
		endcase
	end
	assign dataPhase = (startCnt != fisr_pkg::CNT_MAX) && (rxCnt_r >= startCnt);
	// next byte to send
	always_comb begin
		case (cmd_r)
			fisr_pkg::CMD_QID: begin
				// alternate maker and device for as long as selected
				fetchByte = byteIdx_r[0] ? fisr_pkg::QUAD_DEVICE_ID
					: fisr_pkg::MANUF_ID;
			end
			fisr_pkg::CMD_UID: begin
				fetchByte = fisr_pkg::UNIQUE_ID[{~byteIdx_r[2:0], 3'h7} -: 8];
			end
			fisr_pkg::CMD_JID: begin
				case (byteIdx_r[1:0])
					2'h0: fetchByte = fisr_pkg::MANUF_ID;
					2'h1: fetchByte = fisr_pkg::MEMORY_TYPE;
					default: fetchByte = fisr_pkg::CAPACITY;
				endcase
			end
			fisr_pkg::CMD_PTAB: fetchByte = fisr_pkg::paramTableByte(byteIdx_r);
			fisr_pkg::CMD_READ: begin
				// a miss on the select fields reads erased
				fetchByte = selOk_r ? secMem[regNum_r][byteIdx_r]
					: fisr_pkg::ERASED_BYTE;
			end
			default: fetchByte = fisr_pkg::ERASED_BYTE;
		endcase
	end
	// drive on falling edges, msb first
	always_ff @(posedge clock) begin
		if (rst || pinsS.csN) begin
			ioOut <= 4'h0;
			ioOeN <= 4'hF;
			outByte_r <= '0;
			outPos_r <= '0;
		end else if (sclkFall && dataPhase) begin
			if (cmd_r == fisr_pkg::CMD_QID) begin
				// four lines, high nibble first
				ioOut <= (outPos_r == 3'h0) ? fetchByte[7:4] : outByte_r[7:4];
				outByte_r <= (outPos_r == 3'h0) ? {fetchByte[3:0], 4'h0}
					: {outByte_r[3:0], 4'h0};
				ioOeN <= 4'h0;
				outPos_r <= outPos_r + 3'h4;
			end else begin
				// single line on io[1]
				ioOut <= {2'h0, (outPos_r == 3'h0) ? fetchByte[7] : outByte_r[7], 1'b0};
				outByte_r <= (outPos_r == 3'h0) ? {fetchByte[6:0], 1'b0}
					: {outByte_r[6:0], 1'b0};
				ioOeN <= 4'hD;
				outPos_r <= outPos_r + 3'h1;
			end
		end
	end
	// ==============================
	// self-timed cycles
	fisr_op_timer opTimer (
		.clock(clock),
		.rst(rst),
		.start(timerStart_r),
		.load(timerLoad_r),
		.running(),
		.done(timerDone)
	);
	// start on deselect, finish on timer done
	always_ff @(posedge clock) begin
		if (rst) begin
			status <= '0;
			op_r <= fisr_pkg::OP_NONE;
			opReg_r <= '0;
			timerStart_r <= 1'b0;
			timerLoad_r <= '0;
		end else begin
			timerStart_r <= 1'b0;
			if (timerDone) begin
				op_r <= fisr_pkg::OP_NONE;
				status.busy <= 1'b0;
				status.writeEnableLatch <= 1'b0;
			end
			if (csRise) begin
				case (cmd_r)
					fisr_pkg::CMD_WREN: begin
						if (rxCnt_r == fisr_pkg::CNT_OPCODE) status.writeEnableLatch <= 1'b1;
					end
					fisr_pkg::CMD_WRDI: begin
						if (rxCnt_r == fisr_pkg::CNT_OPCODE) status.writeEnableLatch <= 1'b0;
					end
					fisr_pkg::CMD_ERASE: begin
						// exact length, latch set, select hit, not locked
						if (rxCnt_r == fisr_pkg::CNT_ADDR_DONE
							&& status.writeEnableLatch && selOk_r
							&& !securityLockBits[regNum_r]) begin
							op_r <= fisr_pkg::OP_ERASE;
							opReg_r <= regNum_r;
							status.busy <= 1'b1;
							timerStart_r <= 1'b1;
							timerLoad_r <= ERASE_CYCLES[fisr_pkg::TIMER_W-1:0];
						end
					end
					fisr_pkg::CMD_PROG: begin
						// whole bytes only, at least one taken
						if (progAny_r && progBit_r == 3'h0) begin
							op_r <= fisr_pkg::OP_PROG;
							status.busy <= 1'b1;
							timerStart_r <= 1'b1;
							timerLoad_r <= PROG_CYCLES[fisr_pkg::TIMER_W-1:0];
						end
					end
					default: ;
				endcase
			end
		end
	end
	// erase sweep, one byte per clock at cycle start
	always_ff @(posedge clock) begin
		if (rst || timerStart_r) begin
			erasePtr_r <= '0;
		end else if (op_r == fisr_pkg::OP_ERASE && !erasePtr_r[8]) begin
			erasePtr_r <= erasePtr_r + 9'h001;
		end
	end
	// ==============================
	// storage, not reset: contents are non-volatile
	always_ff @(posedge clock) begin
		if (op_r == fisr_pkg::OP_ERASE && !erasePtr_r[8] && !timerStart_r) begin
			secMem[opReg_r][erasePtr_r[7:0]] <= fisr_pkg::ERASED_BYTE;
		end else if (memWrite) begin
			// program only clears bits, like the cell itself
			secMem[regNum_r][byteIdx_r] <= secMem[regNum_r][byteIdx_r] & shiftNxt[7:0];
		end
	end
endmodule

// ---- verification/fisr_checker.sv ----
`timescale 1ns/1ps
// ==============================
// port-level checks of the id and security register block
module fisr_checker #(
	parameter int unsigned ERASE_CYCLES = 300,
	parameter int unsigned PROG_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst,
	input wire fisr_pkg::fisr_pins_t spiPins,
	input wire logic [2:0] securityLockBits,
	input wire logic powerDown,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOeN,
	input wire fisr_pkg::fisr_status_t status
);
	logic [31:0] busyLen_r; // cycles of the running self-timed cycle
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// count busy cycles, cleared while idle
	always_ff @(posedge clock) begin
		if (rst || !status.busy) begin
			busyLen_r <= 32'h0;
		end else begin
			busyLen_r <= busyLen_r + 32'h1;
		end
	end
	// ==============================
	// steps
	sequence oeStart;
		$past(ioOeN) == 4'hF && ioOeN != 4'hF;
	endsequence
	sequence frameEnd;
		$rose(spiPins.csN);
	endsequence
	// ==============================
	// assertions
	oe_legal_a: assert property (ioOeN inside {4'hF, 4'hD, 4'h0})
		else $error("output enable pattern illegal");
	end_release_a: assert property (frameEnd |-> ##[1:8] ioOeN == 4'hF)
		else $error("pins still driven after deselect");
	drive_in_frame_a: assert property (ioOeN != 4'hF |-> !$past(spiPins.csN, 8))
		else $error("pins driven outside a frame");
	busy_after_cs_a: assert property ($rose(status.busy) |-> spiPins.csN && $past(spiPins.csN, 2))
		else $error("busy began inside a frame");
	busy_needs_latch_a: assert property ($rose(status.busy) |-> $past(status.writeEnableLatch))
		else $error("busy began without write enable");
	latch_held_a: assert property (status.busy |-> status.writeEnableLatch)
		else $error("write enable lost while busy");
	done_clears_latch_a: assert property ($fell(status.busy) |-> !status.writeEnableLatch)
		else $error("write enable kept after cycle end");
	busy_length_a: assert property ($fell(status.busy) |->
		busyLen_r >= PROG_CYCLES && busyLen_r <= ERASE_CYCLES + 8)
		else $error("self-timed cycle length wrong");
	pd_silent_a: assert property (oeStart |-> !powerDown)
		else $error("answer given while powered down");
endmodule
bind fisr_core fisr_checker #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk (
	.clock(clock), .rst(rst), .spiPins(spiPins), .securityLockBits(securityLockBits),
	.powerDown(powerDown), .ioOut(ioOut), .ioOeN(ioOeN), .status(status));

// ---- verification/fisr_host_model.sv ----
`timescale 1ns/1ps
// ==============================
// host spi controller, mode zero, 8 clocks per half period
module fisr_host_model (
	input wire logic clock,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOeN,
	output fisr_pkg::fisr_pins_t spiPins
);
	logic csN = 1'b1; // select, idle high
	logic sclk = 1'b0; // stands low outside frames
	logic [3:0] hostIo = 4'h0; // host side of the data lines
	logic [3:0] lvl; // resolved wire level
	// device wins a line whose enable is low
	assign lvl = (ioOeN & hostIo) | (~ioOeN & ioOut);
	assign spiPins = {csN, sclk, lvl};
	// ==============================
	// frame control
	task automatic csLow();
		csN = 1'b0;
		repeat (8) @(posedge clock);
		#1;
	endtask
	// deselect at once, at any clock count
	task automatic csHigh();
		csN = 1'b1;
		hostIo = ~hostIo; // released lines do not keep their last value
		repeat (8) @(posedge clock);
		#1;
	endtask
	// one clock: data set while low, sampled by device on the rise
	task automatic clk1(input logic quad, input logic [3:0] d, output logic [3:0] q);
		if (quad) begin
			hostIo = d;
		end else begin
			hostIo[0] = d[0];
		end
		repeat (8) @(posedge clock);
		#1 q = lvl;
		sclk = 1'b1;
		repeat (8) @(posedge clock);
		#1 sclk = 1'b0;
	endtask
	// byte out and in, msb first
	task automatic xbyte(input logic quad, input logic [7:0] b, output logic [7:0] q);
		logic [3:0] n;
		for (int i = 0; i < (quad ? 2 : 8); i++) begin
			if (quad) begin
				clk1(1'b1, b[7-4*i -: 4], n);
				q[7-4*i -: 4] = n;
			end else begin
				clk1(1'b0, {3'h0, b[7-i]}, n);
				q[7-i] = n[1];
			end
		end
	endtask
endmodule

// ---- verification/flash_id_and_security_regs_bench.sv ----
`timescale 1ns/1ps
// ==============================
// command-level bench of the id and security register block
module flash_id_and_security_regs_bench;
	localparam int ERASE_N = 2000; // long enough to hold a frame
	localparam int PROG_N = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] lockBits = 3'h0;
	logic powerDown = 1'b0;
	fisr_pkg::fisr_pins_t spiPins;
	logic [3:0] ioOut;
	logic [3:0] ioOeN;
	fisr_pkg::fisr_status_t status;
	logic [7:0] d; // last byte read back
	logic [3:0] n;
	int err_count = 0;
	int checks_done = 0;
	initial forever #2 clock = ~clock;
	fisr_core #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) dut (.clock(clock), .rst(rst),
		.spiPins(spiPins), .securityLockBits(lockBits), .powerDown(powerDown),
		.ioOut(ioOut), .ioOeN(ioOeN), .status(status));
	fisr_host_model host (.clock(clock), .ioOut(ioOut), .ioOeN(ioOeN), .spiPins(spiPins));
	// ==============================
	// helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// opcode then nb header bytes taken from the top of a
	task automatic send(input logic [7:0] op, input int nb, input logic [31:0] a);
		host.csLow();
		host.xbyte(1'b0, op, d);
		for (int i = 0; i < nb; i++) begin
			host.xbyte(1'b0, a[31-8*i -: 8], d);
		end
	endtask
	task automatic rd(input string nm, input logic quad, input logic [7:0] e);
		host.xbyte(quad, 8'h00, d);
		check(nm, d, e);
	endtask
	task automatic stat(input logic b, input logic w);
		check("busy", {7'h0, status.busy}, {7'h0, b});
		check("latch", {7'h0, status.writeEnableLatch}, {7'h0, w});
	endtask
	task automatic wren();
		send(fisr_pkg::OPC_WRITE_ENABLE, 0, 32'h0);
		host.csHigh();
	endtask
	// bounded wait for the self-timed cycle to end
	task automatic waitIdle(input int lim);
		int k;
		k = 0;
		while (status.busy !== 1'b0 && k < lim) begin
			@(posedge clock);
			#1;
			k++;
		end
		#1;
		if (k >= lim) begin
			err_count++;
			end_of_test();
		end
	endtask
	// ==============================
	// main sequence
	initial begin
		repeat (4) @(posedge clock);
		#1 rst = 1'b0;
		repeat (8) @(posedge clock);
		#1;
		// three-byte id, then release on deselect
		send(fisr_pkg::OPC_JEDEC_ID, 0, 32'h0);
		rd("maker", 1'b0, fisr_pkg::MANUF_ID);
		rd("type", 1'b0, fisr_pkg::MEMORY_TYPE);
		rd("capacity", 1'b0, fisr_pkg::CAPACITY);
		check("enable", {4'h0, ioOeN}, 8'h0D);
		host.csHigh();
		check("enable", {4'h0, ioOeN}, 8'h0F);
		// quad id: dummy nibbles carry the Fx mode pattern, address zero
		send(fisr_pkg::OPC_QUAD_ID, 0, 32'h0);
		repeat (4) host.clk1(1'b1, 4'hF, n);
		repeat (3) host.xbyte(1'b1, 8'h00, d);
		for (int k = 0; k < 4; k++) begin
			rd("quad id", 1'b1, k[0] ? fisr_pkg::QUAD_DEVICE_ID : fisr_pkg::MANUF_ID);
		end
		check("enable", {4'h0, ioOeN}, 8'h00);
		host.csHigh();
		// unique id after four dummy bytes, ninth byte wraps
		send(fisr_pkg::OPC_UNIQUE_ID, 4, 32'h0);
		for (int k = 0; k < 9; k++) begin
			rd("unique", 1'b0, fisr_pkg::UNIQUE_ID[63-8*(k%8) -: 8]);
		end
		host.csHigh();
		// table read from the last byte
		send(fisr_pkg::OPC_PARAM_TABLE, 4, 32'h0000FF00);
		rd("table", 1'b0, 8'hFF);
		rd("table", 1'b0, 8'h50);
		rd("table", 1'b0, 8'h54);
		host.csHigh();
		// erase refused once write enable is withdrawn
		wren();
		send(fisr_pkg::OPC_WRITE_DISABLE, 0, 32'h0);
		host.csHigh();
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00100000);
		host.csHigh();
		stat(1'b0, 1'b0);
		// erase dropped when one clock too many
		wren();
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00100000);
		host.clk1(1'b0, 4'h0, n);
		host.csHigh();
		stat(1'b0, 1'b1);
		// valid erase; a register read meanwhile is ignored
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00100000);
		host.csHigh();
		stat(1'b1, 1'b1);
		send(fisr_pkg::OPC_SEC_READ, 4, 32'h00100000);
		host.xbyte(1'b0, 8'h00, d);
		check("enable", {4'h0, ioOeN}, 8'h0F);
		host.csHigh();
		stat(1'b1, 1'b1);
		waitIdle(ERASE_N);
		stat(1'b0, 1'b0);
		// program two erased bytes across the wrap point
		wren();
		send(fisr_pkg::OPC_SEC_PROG, 3, 32'h0010FF00);
		host.xbyte(1'b0, 8'hA5, d);
		host.xbyte(1'b0, 8'h3C, d);
		host.csHigh();
		stat(1'b1, 1'b1);
		waitIdle(200);
		stat(1'b0, 1'b0);
		send(fisr_pkg::OPC_SEC_READ, 4, 32'h0010FE00);
		rd("secreg", 1'b0, 8'hFF);
		rd("secreg", 1'b0, 8'hA5);
		rd("secreg", 1'b0, 8'h3C);
		rd("secreg", 1'b0, 8'hFF);
		host.csHigh();
		// locked register ignores erase and program
		lockBits = 3'h1;
		wren();
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00100000);
		host.csHigh();
		stat(1'b0, 1'b1);
		send(fisr_pkg::OPC_SEC_PROG, 4, 32'h00100100);
		host.csHigh();
		stat(1'b0, 1'b1);
		send(fisr_pkg::OPC_SEC_READ, 4, 32'h00100100);
		rd("locked", 1'b0, 8'hFF);
		host.csHigh();
		// bad select refused, second register erased alone
		lockBits = 3'h0;
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00400000);
		host.csHigh();
		stat(1'b0, 1'b1);
		send(fisr_pkg::OPC_SEC_ERASE, 3, 32'h00200000);
		host.csHigh();
		stat(1'b1, 1'b1);
		waitIdle(ERASE_N);
		send(fisr_pkg::OPC_SEC_READ, 4, 32'h0010FF00);
		rd("other reg", 1'b0, 8'hA5);
		host.csHigh();
		// powered down: no answer
		powerDown = 1'b1;
		send(fisr_pkg::OPC_JEDEC_ID, 0, 32'h0);
		host.xbyte(1'b0, 8'h00, d);
		check("enable", {4'h0, ioOeN}, 8'h0F);
		host.csHigh();
		powerDown = 1'b0;
		end_of_test();
	end
endmodule
